// File: spi_port.sv
// SPI master/slave port with APB register access
//
// Behaviour
// - Master starts shifting as soon as software writes the data buffer; here that write is refused while the collision flag is still set.
// - With output unused, the port still receives and loads bytes with flags.
// - Master rate is clock/4, /16, /64, timer pulse/2 or reload-based.
// - Clock idle level follows polarity bit; transmit edge follows edge select.
// - With edge select set, output data is valid before first clock edge.
// - Slave shifts only on external clock edges; flag set after last bit.
// - Slave keeps shifting in sleep; completed byte sets the waking flag.
// - With overwrite enable, new bytes and writes ignore unread buffer data.
// - Daisy-chained slave sends out a copy of the byte just received.
// - Select-synchronised slave mode only when mode field is 0100.
// - In that mode, select low enables transfer and drives data out.
// - In that mode, select high floats data output even mid-byte.
// - Port reset clears bit counter: select high there, or port disabled.
// - Master transfer freezes during sleep and resumes on wake.
// - Completed byte goes to buffer unless it is full without overwrite enable, sets full and event flags; buffer read clears full.
// - Buffer write during transfer is dropped and sets collision flag.
// - Data moves MSB first through an 8-bit shift register.
// - Sample phase bit picks middle or end of output time for master input.
//
// Chosen here: the register addresses and register access over APB.
module spi_port
  import spi_port_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // Register bus
  input  wire apb_req_t      apb_req,
  output spi_port_pkg::apb_rsp_t apb_rsp,
  // Serial pins
  input  wire spi_pins_in_t  pins_in,
  output spi_port_pkg::spi_pins_out_t pins_out,
  // System
  input  wire logic          sleep_mode,
  input  wire logic          period_tick,
  output logic               serial_interrupt_flag
);
  import spi_port_pkg::*;

  typedef struct packed {
    apb_rsp_t      rsp;
    spi_pins_out_t pins;
    logic [7:0]    data_buffer;
    logic [7:0]    baud_reload_value;
    logic          write_collision_flag;
    logic          receive_overflow_flag;
    logic          port_enable;
    logic          clock_polarity_sel;
    logic [3:0]    mode_select_field;
    logic          buffer_overwrite_enable;
    logic          input_sample_phase;
    logic          clock_edge_sel;
    logic          buffer_full_flag;
    logic          serial_interrupt_flag;
    xfer_state_t   xfer;
    logic [4:0]    half_cnt;
    logic [2:0]    bit_cnt;
    logic [7:0]    shift_register;
    logic [7:0]    tx_shift;
    logic          sck_prev;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;

  logic [1:0] line_sync;
  logic       sck_sync;
  logic       ss_n_sync;
  logic       half_tick;
  logic       is_master;
  logic       sleep_hold;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == DATA_BUFFER_OFS) || (addr == CONTROL_ONE_OFS)
             || (addr == CONTROL_THREE_OFS) || (addr == STATUS_OFS)
             || (addr == BAUD_RELOAD_OFS) || (addr == EVENT_FLAGS_OFS);
  endfunction

  function automatic logic master_mode(input logic [3:0] mode);
    master_mode = (mode != MODE_SLAVE_SS) && (mode != MODE_SLAVE_NOSS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Submodules

  spi_line_sync u_sync (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .line_in   ({pins_in.sck_in, pins_in.ss_n}),
    .line_sync (line_sync)
  );

  assign sck_sync   = line_sync[1];
  assign ss_n_sync  = line_sync[0];
  assign is_master  = master_mode(s.mode_select_field);
  assign sleep_hold = sleep_mode && is_master;

  spi_rate_gen u_rate (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .mode        (s.mode_select_field),
    .reload      (s.baud_reload_value),
    .period_tick (period_tick),
    .run         (s.xfer == XFER_SHIFT),
    .hold        (sleep_hold),
    .half_tick   (half_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic       taken;
    logic       wr;
    logic       busy;
    logic       ss_mode;
    logic       port_reset;
    logic       slave_on;
    logic       lead_edge;
    logic       trail_edge;
    logic       do_sample;
    logic       do_output;
    logic       done;
    logic [4:0] hn;
    logic [4:0] end_edge;
    logic [7:0] rx_byte;
    logic [7:0] wdat;

    taken      = 1'b0;
    wr         = 1'b0;
    busy       = 1'b0;
    ss_mode    = 1'b0;
    port_reset = 1'b0;
    slave_on   = 1'b0;
    lead_edge  = 1'b0;
    trail_edge = 1'b0;
    do_sample  = 1'b0;
    do_output  = 1'b0;
    done       = 1'b0;
    hn         = 5'h00;
    end_edge   = 5'h00;
    rx_byte    = 8'h00;
    wdat       = apb_req.pwdata[7:0];
    next_s     = s;

    // Bus answer: one wait state, then pready for a single cycle
    next_s.rsp.pready  = 1'b0;
    next_s.rsp.pslverr = 1'b0;
    if (apb_req.psel && apb_req.penable && !s.rsp.pready) begin
      next_s.rsp.pready  = 1'b1;
      next_s.rsp.pslverr = !is_mapped(apb_req.paddr);
      next_s.rsp.prdata  = 32'h0000_0000;
      if (apb_req.paddr == DATA_BUFFER_OFS) begin
        next_s.rsp.prdata[7:0] = s.data_buffer;
      end else if (apb_req.paddr == CONTROL_ONE_OFS) begin
        next_s.rsp.prdata[7:0] = {s.write_collision_flag, s.receive_overflow_flag,
                                  s.port_enable, s.clock_polarity_sel,
                                  s.mode_select_field};
      end else if (apb_req.paddr == CONTROL_THREE_OFS) begin
        next_s.rsp.prdata[OVWR_BIT] = s.buffer_overwrite_enable;
      end else if (apb_req.paddr == STATUS_OFS) begin
        next_s.rsp.prdata[SAMP_BIT] = s.input_sample_phase;
        next_s.rsp.prdata[CKE_BIT]  = s.clock_edge_sel;
        next_s.rsp.prdata[FULL_BIT] = s.buffer_full_flag;
      end else if (apb_req.paddr == BAUD_RELOAD_OFS) begin
        next_s.rsp.prdata[7:0] = s.baud_reload_value;
      end else if (apb_req.paddr == EVENT_FLAGS_OFS) begin
        next_s.rsp.prdata[IFLAG_BIT] = s.serial_interrupt_flag;
      end
    end
    taken = apb_req.psel && apb_req.penable && s.rsp.pready;
    wr    = taken && apb_req.pwrite;

    busy = is_master ? (s.xfer == XFER_SHIFT) : (s.bit_cnt != 3'h0);

    // Software side; flags are cleared here so hardware sets below win
    if (taken && !apb_req.pwrite && apb_req.paddr == DATA_BUFFER_OFS) begin
      next_s.buffer_full_flag = 1'b0;
    end
    if (wr) begin
      if (apb_req.paddr == DATA_BUFFER_OFS) begin
        if (busy || s.write_collision_flag || !s.port_enable) begin
          next_s.write_collision_flag = busy || s.write_collision_flag;
        end else begin
          // Buffer and shift path load together, MSB presented at once
          next_s.data_buffer  = wdat;
          next_s.tx_shift     = {wdat[6:0], 1'b0};
          next_s.pins.sdo_out = wdat[7];
          if (is_master) begin
            next_s.xfer     = XFER_SHIFT;
            next_s.half_cnt = 5'h00;
            next_s.bit_cnt  = 3'h0;
          end
        end
      end else if (apb_req.paddr == CONTROL_ONE_OFS) begin
        // Status bits here can only be cleared by software
        next_s.write_collision_flag  = s.write_collision_flag && wdat[COLL_BIT];
        next_s.receive_overflow_flag = s.receive_overflow_flag && wdat[OVF_BIT];
        next_s.port_enable           = wdat[EN_BIT];
        next_s.clock_polarity_sel    = wdat[CPOL_BIT];
        next_s.mode_select_field     = wdat[3:0];
      end else if (apb_req.paddr == CONTROL_THREE_OFS) begin
        next_s.buffer_overwrite_enable = wdat[OVWR_BIT];
      end else if (apb_req.paddr == STATUS_OFS) begin
        next_s.input_sample_phase = wdat[SAMP_BIT];
        next_s.clock_edge_sel     = wdat[CKE_BIT];
      end else if (apb_req.paddr == BAUD_RELOAD_OFS) begin
        next_s.baud_reload_value = wdat;
      end else if (apb_req.paddr == EVENT_FLAGS_OFS) begin
        next_s.serial_interrupt_flag = s.serial_interrupt_flag && wdat[IFLAG_BIT];
      end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial engine

    ss_mode    = (s.mode_select_field == MODE_SLAVE_SS);
    port_reset = !s.port_enable || (ss_mode && ss_n_sync);
    slave_on   = s.port_enable && !is_master && !port_reset;
    next_s.sck_prev = sck_sync;
    // Edges seen only after synchronising, so flags never see a raw pin
    lead_edge  = (sck_sync != s.sck_prev) && (s.sck_prev == s.clock_polarity_sel);
    trail_edge = (sck_sync != s.sck_prev) && (s.sck_prev != s.clock_polarity_sel);

    if (s.port_enable && is_master && s.xfer == XFER_SHIFT) begin
      if (half_tick) begin
        hn              = s.half_cnt + 5'h01;
        next_s.half_cnt = hn;
        if (hn <= LAST_CLK_EDGE) begin
          next_s.pins.sck_out = !s.pins.sck_out;
        end
        // Sample phase moves the capture half a bit later
        do_sample = !(hn[0] ^ s.clock_edge_sel ^ s.input_sample_phase)
                 && (hn > {4'h0, s.input_sample_phase});
        do_output = (hn[0] ^ s.clock_edge_sel) && (hn >= 5'h02) && (hn < LAST_CLK_EDGE);
        end_edge  = LAST_CLK_EDGE
                  + {4'h0, s.input_sample_phase && !s.clock_edge_sel};
        if (hn == end_edge) begin
          done        = 1'b1;
          next_s.xfer = XFER_IDLE;
        end
      end
    end else if (slave_on) begin
      // Runs regardless of sleep: timing comes from the far master
      do_sample = s.clock_edge_sel ? lead_edge : trail_edge;
      do_output = (s.clock_edge_sel ? trail_edge : lead_edge) && (s.bit_cnt != 3'h0);
      done      = do_sample && (s.bit_cnt == LAST_BIT);
    end

    if (do_sample) begin
      // Input keeps being taken even when the output pin is unused
      next_s.shift_register = {s.shift_register[6:0], pins_in.sdi};
      next_s.bit_cnt        = s.bit_cnt + 3'h1;
    end
    if (do_output) begin
      next_s.pins.sdo_out = s.tx_shift[7];
      next_s.tx_shift     = {s.tx_shift[6:0], 1'b0};
    end

    if (done) begin
      rx_byte = {s.shift_register[6:0], pins_in.sdi};
      if (is_master) begin
        rx_byte = next_s.shift_register;
      end
      if (!s.buffer_full_flag || s.buffer_overwrite_enable) begin
        next_s.data_buffer      = rx_byte;
      end else begin
        next_s.receive_overflow_flag = 1'b1;
      end
      next_s.buffer_full_flag      = 1'b1;
      next_s.serial_interrupt_flag = 1'b1;
      next_s.bit_cnt               = 3'h0;
      // Received byte goes straight back out on the next group of clocks
      next_s.tx_shift     = {rx_byte[6:0], 1'b0};
      next_s.pins.sdo_out = rx_byte[7];
    end

    if (port_reset) begin
      next_s.bit_cnt  = 3'h0;
      next_s.half_cnt = 5'h00;
      next_s.xfer     = XFER_IDLE;
    end
    if (!is_master || next_s.xfer == XFER_IDLE) begin
      next_s.pins.sck_out = s.clock_polarity_sel;
    end

    // Pin drivers
    next_s.pins.sck_oe = s.port_enable && is_master;
    if (ss_mode) begin
      next_s.pins.sdo_oe = s.port_enable && !ss_n_sync;
    end else begin
      next_s.pins.sdo_oe = s.port_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{
        rsp:                     '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000},
        pins:                    '{sck_out: 1'b0, sck_oe: 1'b0, sdo_out: 1'b0,
                                   sdo_oe: 1'b0},
        data_buffer:             DATA_RESET,
        baud_reload_value:       CONTROL_RESET,
        write_collision_flag:    1'b0,
        receive_overflow_flag:   1'b0,
        port_enable:             1'b0,
        clock_polarity_sel:      1'b0,
        mode_select_field:       4'h0,
        buffer_overwrite_enable: 1'b0,
        input_sample_phase:      1'b0,
        clock_edge_sel:          1'b0,
        buffer_full_flag:        1'b0,
        serial_interrupt_flag:   1'b0,
        xfer:                    XFER_IDLE,
        half_cnt:                5'h00,
        bit_cnt:                 3'h0,
        shift_register:          DATA_RESET,
        tx_shift:                DATA_RESET,
        sck_prev:                1'b0
      };
    end else begin
      s <= next_s;
    end
  end

  assign apb_rsp               = s.rsp;
  assign pins_out              = s.pins;
  assign serial_interrupt_flag = s.serial_interrupt_flag;

endmodule

// File: spi_port_pkg.sv
// Constants, register layout and carrier types of the SPI port
package spi_port_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] DATA_BUFFER_OFS  = 8'h00;
  localparam logic [7:0] CONTROL_ONE_OFS  = 8'h04;
  localparam logic [7:0] CONTROL_THREE_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS       = 8'h0C;
  localparam logic [7:0] BAUD_RELOAD_OFS  = 8'h10;
  localparam logic [7:0] EVENT_FLAGS_OFS  = 8'h14;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int COLL_BIT  = 7;
  localparam int OVF_BIT   = 6;
  localparam int EN_BIT    = 5;
  localparam int CPOL_BIT  = 4;
  localparam int OVWR_BIT  = 4;
  localparam int SAMP_BIT  = 7;
  localparam int CKE_BIT   = 6;
  localparam int FULL_BIT  = 0;
  localparam int IFLAG_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET     = 8'h00;
  localparam logic [9:0] HALF_DIV4      = 10'h002;
  localparam logic [9:0] HALF_DIV16     = 10'h008;
  localparam logic [9:0] HALF_DIV64     = 10'h020;
  localparam logic [4:0] LAST_CLK_EDGE  = 5'h10;
  localparam logic [2:0] LAST_BIT       = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // Modes and states
  typedef enum logic [3:0] {
    MODE_DIV4       = 4'b0000,
    MODE_DIV16      = 4'b0001,
    MODE_DIV64      = 4'b0010,
    MODE_TIMER      = 4'b0011,
    MODE_SLAVE_SS   = 4'b0100,
    MODE_SLAVE_NOSS = 4'b0101,
    MODE_RELOAD     = 4'b1010
  } mode_t;

  typedef enum logic [0:0] {
    XFER_IDLE  = 1'b0,
    XFER_SHIFT = 1'b1
  } xfer_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic sck_in;
    logic sdi;
    logic ss_n;
  } spi_pins_in_t;

  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic sdo_out;
    logic sdo_oe;
  } spi_pins_out_t;

endpackage

// File: spi_line_sync.sv
// Two-flop synchroniser for the serial clock and slave select inputs
module spi_line_sync (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Lines
  input  wire logic [1:0] line_in,
  output logic      [1:0] line_sync
);

  typedef struct packed {
    logic [1:0] first;
    logic [1:0] second;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s        = s;
    next_s.first  = line_in;
    next_s.second = s.first;
  end

  // Idle-high reset keeps a deselected slave from seeing a false edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{first: 2'h3, second: 2'h3};
    end else begin
      s <= next_s;
    end
  end

  assign line_sync = s.second;

endmodule

// File: spi_rate_gen.sv
// Half-bit tick generator for the master serial clock
module spi_rate_gen
  import spi_port_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Control
  input  wire logic [3:0] mode,
  input  wire logic [7:0] reload,
  input  wire logic       period_tick,
  input  wire logic       run,
  input  wire logic       hold,
  // Tick
  output logic            half_tick
);

  typedef struct packed {
    logic [9:0] cnt;
  } rate_state_t;

  rate_state_t s;
  rate_state_t next_s;
  logic [9:0]  limit;

  always_comb begin
    if (mode == MODE_DIV16) begin
      limit = HALF_DIV16;
    end else if (mode == MODE_DIV64) begin
      limit = HALF_DIV64;
    end else if (mode == MODE_RELOAD) begin
      limit = {1'b0, reload, 1'b0} + 10'h002;
    end else begin
      limit = HALF_DIV4;
    end
    if (mode == MODE_TIMER) begin
      half_tick = run && !hold && period_tick;
    end else begin
      half_tick = run && !hold && (s.cnt == limit - 10'h001);
    end
    next_s = s;
    if (!run) begin
      next_s.cnt = 10'h000;
    end else if (hold) begin
      next_s.cnt = s.cnt;
    end else if (half_tick) begin
      next_s.cnt = 10'h000;
    end else begin
      next_s.cnt = s.cnt + 10'h001;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{cnt: 10'h000};
    end else begin
      s <= next_s;
    end
  end

endmodule

// File: spi_port_asserts.sv
// Assertions on the SPI port pins and register bus
module spi_port_asserts
  import spi_port_pkg::*;
(
  // Clock and reset
  input wire logic          core_clk,
  input wire logic          reset_n,
  // Bus and pins
  input wire apb_req_t      apb_req,
  input wire apb_rsp_t      apb_rsp,
  input wire spi_pins_in_t  pins_in,
  input wire spi_pins_out_t pins_out,
  input wire logic          sleep_mode,
  input wire logic          period_tick,
  input wire logic          serial_interrupt_flag
);
  logic [7:0] ctl;
  logic [3:0] rises;
  logic       wr_fx;
  logic       m_on;
  logic       s_on;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  assign wr_fx = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
  assign m_on = ctl[EN_BIT] && ctl[3:0] != MODE_SLAVE_SS && ctl[3:0] != MODE_SLAVE_NOSS;
  assign s_on = ctl[EN_BIT] && ctl[3:0] == MODE_SLAVE_SS;
  // Refused buffer writes must not restart the edge count
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl   <= CONTROL_RESET;
      rises <= 4'h0;
    end else begin
      if (wr_fx && apb_req.paddr == CONTROL_ONE_OFS)
        ctl <= apb_req.pwdata[7:0];
      if ((wr_fx && apb_req.paddr != DATA_BUFFER_OFS) || $rose(serial_interrupt_flag))
        rises <= 4'h0;
      else if ($changed(pins_out.sck_out) && pins_out.sck_out != ctl[CPOL_BIT])
        rises <= rises + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_one_wait;
    !apb_rsp.pready ##1 apb_rsp.pready;
  endsequence
  a_apb_one_wait: assert property (s_setup |=> s_one_wait)
    else $error("register answer not after one wait state");
  a_sleep_freeze: assert property (m_on && sleep_mode ##1 sleep_mode |=>
    $stable(pins_out.sck_out) && $stable(pins_out.sdo_out))
    else $error("master pins moved during sleep");
  a_byte_edges: assert property (m_on && $rose(serial_interrupt_flag) |-> rises == 4'h8)
    else $error("byte done without eight clock periods");
  a_idle_level: assert property (m_on && $rose(serial_interrupt_flag)
    |-> pins_out.sck_out == ctl[CPOL_BIT])
    else $error("master clock not at idle level after byte");
  a_master_drives: assert property (m_on [*3] |-> pins_out.sck_oe)
    else $error("master not driving serial clock");
  a_ss_drive: assert property ((s_on && !pins_in.ss_n) [*5] |-> pins_out.sdo_oe)
    else $error("selected slave not driving data out");
  a_ss_release: assert property ((s_on && pins_in.ss_n) [*5] |-> !pins_out.sdo_oe)
    else $error("deselected slave still driving data out");
  a_slave_quiet: assert property ((s_on && $stable(pins_in.sck_in)) [*6]
    |-> !$rose(serial_interrupt_flag))
    else $error("slave flag rose without clock pulses");
  a_slave_no_sck: assert property (s_on ##1 s_on |-> !pins_out.sck_oe)
    else $error("slave driving serial clock");
endmodule

bind spi_port spi_port_asserts spi_port_asserts_inst (
  .core_clk(core_clk), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .pins_in(pins_in), .pins_out(pins_out), .sleep_mode(sleep_mode),
  .period_tick(period_tick), .serial_interrupt_flag(serial_interrupt_flag));

// File: spi_far_end.sv
// Far-side SPI device: answers as slave or acts as the remote master
module spi_far_end
  import spi_port_pkg::*;
(
  // Clock
  input  wire logic          core_clk,
  // Role and data
  input  wire logic          master_role,
  input  wire logic [7:0]    reply_byte,
  output logic      [7:0]    got_byte,
  // Pins
  input  wire spi_pins_out_t pins_out,
  output spi_pins_in_t       pins_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt;
  initial begin
    cnt      = 3'h0;
    got_byte = 8'h00;
    pins_in  = '{sck_in: 1'b0, sdi: 1'b0, ss_n: 1'b1};
  end
  // Slave role: capture on rising edge, shift out on falling edge
  always @(posedge pins_out.sck_out) begin
    if (!master_role) begin
      got_byte <= {got_byte[6:0], pins_out.sdo_out};
      cnt      <= cnt + 3'h1;
    end
  end
  always @(negedge pins_out.sck_out or reply_byte) begin
    if (!master_role)
      pins_in.sdi <= reply_byte[3'h7 - cnt];
  end
  // Master role: slow clock so the port's synchroniser keeps up
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge core_clk);
    pins_in.ss_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      pins_in.sdi <= tx[7 - i];
      repeat (8) @(posedge core_clk);
      rx = {rx[6:0], pins_out.sdo_out};
      pins_in.sck_in <= 1'b1;
      repeat (8) @(posedge core_clk);
      pins_in.sck_in <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
    pins_in.ss_n <= 1'b1;
    pins_in.sdi  <= ~pins_in.sdi;
  endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the SPI port
module tb_top
  import spi_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          core_clk = 1'b0;
  logic          reset_n = 1'b0;
  apb_req_t      apb_req = '0;
  apb_rsp_t      apb_rsp;
  spi_pins_in_t  pins_in;
  spi_pins_out_t pins_out;
  logic          sleep_mode = 1'b0;
  logic          period_tick = 1'b0;
  logic          serial_interrupt_flag;
  logic          master_role = 1'b0;
  logic [7:0]    reply_byte = 8'h3C;
  logic [7:0]    got_byte;
  logic [2:0]    tick_cnt = 3'h0;
  int            num_errors = 0;
  int            num_checks = 0;
  logic [7:0] rate_ctl [5] = '{8'h20, 8'h31, 8'h22, 8'h3A, 8'h23};
  logic [7:0] rate_rl [5] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  // Clock periods: 4, 16, 64 cycles, 4*(3+1), two ticks of 5
  logic [31:0] rate_per [5] = '{32'h4, 32'h10, 32'h40, 32'h10, 32'hA};

  spi_port spi_port_inst (.core_clk(core_clk), .reset_n(reset_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .pins_in(pins_in), .pins_out(pins_out), .sleep_mode(sleep_mode),
    .period_tick(period_tick), .serial_interrupt_flag(serial_interrupt_flag));
  spi_far_end spi_far_end_inst (.core_clk(core_clk), .master_role(master_role),
    .reply_byte(reply_byte), .got_byte(got_byte), .pins_out(pins_out), .pins_in(pins_in));

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    tick_cnt    <= (tick_cnt == 3'h4) ? 3'h0 : tick_cnt + 3'h1;
    period_tick <= (tick_cnt == 3'h4);
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge core_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    if (n >= 20) num_errors++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h000000, d}, r, e);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, r, exp);
  endtask
  task automatic wait_flag;
    int n;
    n = 0;
    while (serial_interrupt_flag !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    chk("flag", {31'h0, serial_interrupt_flag}, 32'h1);
    wr(EVENT_FLAGS_OFS, 8'h00);
  endtask
  task automatic sck_period(output logic [31:0] p);
    int n;
    logic prev;
    p = 0;
    n = 0;
    prev = pins_out.sck_out;
    while (n < 2 && p < 400) begin
      @(posedge core_clk);
      if (n == 1) p++;
      if (pins_out.sck_out && !prev) n++;
      prev = pins_out.sck_out;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic e;
    logic [7:0] rx;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    rd_chk("ctl one", CONTROL_ONE_OFS, {24'h0, CONTROL_RESET});
    rd_chk("buffer", DATA_BUFFER_OFS, {24'h0, DATA_RESET});
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    // Master byte with a refused second write
    wr(STATUS_OFS, 8'h40);
    wr(CONTROL_ONE_OFS, 8'h20);
    wr(DATA_BUFFER_OFS, 8'hA5);
    wr(DATA_BUFFER_OFS, 8'h11);
    rd_chk("collision", CONTROL_ONE_OFS, 32'hA0);
    wait_flag();
    chk("sent", {24'h0, got_byte}, 32'hA5);
    rd_chk("full", STATUS_OFS, 32'h41);
    rd_chk("received", DATA_BUFFER_OFS, 32'h3C);
    rd_chk("emptied", STATUS_OFS, 32'h40);
    wr(CONTROL_ONE_OFS, 8'h22);
    rd_chk("flag clear", EVENT_FLAGS_OFS, 32'h0);
    // Master byte frozen by sleep
    reply_byte = 8'h69;
    wr(DATA_BUFFER_OFS, 8'h96);
    repeat (70) @(posedge core_clk);
    sleep_mode <= 1'b1;
    repeat (200) @(posedge core_clk);
    chk("frozen", {31'h0, serial_interrupt_flag}, 32'h0);
    sleep_mode <= 1'b0;
    wait_flag();
    chk("resumed", {24'h0, got_byte}, 32'h96);
    rd_chk("resumed rx", DATA_BUFFER_OFS, 32'h69);
    for (int i = 0; i < 5; i++) begin
      wr(BAUD_RELOAD_OFS, rate_rl[i]);
      wr(CONTROL_ONE_OFS, rate_ctl[i]);
      repeat (4) @(posedge core_clk);
      chk("idle sck", {31'h0, pins_out.sck_out}, {31'h0, rate_ctl[i][CPOL_BIT]});
      wr(DATA_BUFFER_OFS, 8'h00);
      sck_period(r);
      chk("sck period", r, rate_per[i]);
      wait_flag();
      apb(1'b0, DATA_BUFFER_OFS, 32'h0, r, e);
    end
    // Slave with select synchronisation
    master_role <= 1'b1;
    wr(CONTROL_ONE_OFS, 8'h00);
    wr(CONTROL_ONE_OFS, 8'h24);
    spi_far_end_inst.xfer(8'h5A, 8, rx);
    wait_flag();
    rd_chk("slave rx", DATA_BUFFER_OFS, 32'h5A);
    sleep_mode <= 1'b1;
    spi_far_end_inst.xfer(8'hC3, 8, rx);
    sleep_mode <= 1'b0;
    chk("chain copy", {24'h0, rx}, 32'h5A);
    wait_flag();
    rd_chk("sleep rx", DATA_BUFFER_OFS, 32'hC3);
    spi_far_end_inst.xfer(8'hFF, 4, rx);
    repeat (5) @(posedge core_clk);
    chk("released", {31'h0, pins_out.sdo_oe}, 32'h0);
    spi_far_end_inst.xfer(8'h96, 8, rx);
    wait_flag();
    rd_chk("realigned", DATA_BUFFER_OFS, 32'h96);
    tally_and_finish();
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    num_errors++;
    tally_and_finish();
  end
endmodule
